// ---- common/asc_defines.svh ----
// Purpose: Shared constants for the converter start and bus control pair.
// Assumes: 250 MHz system clock on both ends.
// Notes:   Times are in ns; cycle counts derive from them, least times rounded up.
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_CLK_PERIOD_NS  4
`define ASC_DATA_W         8
`define ASC_LATCH_RST      8'h00
// Strobe width the host holds cs/rd/wr low, before any wait states
`define ASC_STROBE_NS      40
`define ASC_STROBE_CYC     ((`ASC_STROBE_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
// Free-running kick pulse after reset, long enough to cross the device synchronisers
`define ASC_INIT_PULSE_NS  40
`define ASC_INIT_CYC       ((`ASC_INIT_PULSE_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
// Self-clocked oscillator: one conversion step every this many system clocks
`define ASC_RC_DIV         25
// Host-derived conversion clock: half period in system clocks
`define ASC_CPU_CLK_HALF   4
`define ASC_BURST_LEN      16
`define ASC_WAIT_STATES    0
`define ASC_PORT_ADDR      8'h40
`define ASC_MEM_ADDR       16'h4000

`endif

// ---- common/asc_pkg.sv ----
// Purpose: Types shared by the converter end and the host end.
// Assumes: Constants come from asc_defines.svh.
// Notes:   Enums carry no explicit codes.
`default_nettype none

package asc_pkg;
  typedef enum logic {ASC_CLK_EXT, ASC_CLK_RC} asc_clk_src_t;
  typedef enum logic {ASC_MAP_IO, ASC_MAP_MEM} asc_map_t;
  typedef enum logic {DEV_IDLE, DEV_CONV} asc_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_WRITE, H_WAIT, H_READ, H_STORE} asc_host_state_t;
endpackage : asc_pkg

`default_nettype wire

// ---- common/asc_if.sv ----
// Purpose: Pin-level link between the host and the converter.
// Assumes: All strobes active low; one system clock on both sides.
// Notes:   The data bus floats high when the converter does not drive it.
`default_nettype none

interface asc_if;
  // Host-driven control pins
  logic       device_select_n;
  logic       start_strobe_n;
  logic       read_strobe_n;
  logic       clock_input_pin;
  // Converter-driven pins
  logic       conversion_done_n;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] bus_data;

  // Resolved bus level, pulled up while undriven
  assign bus_data = dev_data_oe ? dev_data : 8'hFF;

  modport dev (
    input  device_select_n, start_strobe_n, read_strobe_n, clock_input_pin,
    output conversion_done_n, dev_data, dev_data_oe
  );
  modport host (
    output device_select_n, start_strobe_n, read_strobe_n, clock_input_pin,
    input  conversion_done_n, bus_data
  );
endinterface : asc_if

`default_nettype wire

// ---- src/asc_converter.sv ----
// Purpose: Converter end: start/restart sequencing, result latch, done flag, bus drive.
// Assumes: Pins from the host are asynchronous and pass two flops before use.
// Notes:   Successive approximation against a digital stand-in for the analog input.
`default_nettype none
`include "asc_defines.svh"

module asc_converter #(
  parameter int DATA_W = `ASC_DATA_W,
  parameter int RC_DIV = `ASC_RC_DIV
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // Pins toward the host
  asc_if.dev                        bus,
  // Converter side
  input  wire asc_pkg::asc_clk_src_t clk_src_i,
  input  wire logic [DATA_W-1:0]    analog_code_i,
  // Status
  output logic                      busy_o,
  output logic [DATA_W-1:0]         result_o,
  output logic                      completed_o,
  output logic                      aborted_o
);
  import asc_pkg::*;

  localparam int IDX_W = $clog2(DATA_W);
  localparam int OSC_W = $clog2(RC_DIV);
  localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(DATA_W - 1);
  localparam logic [OSC_W-1:0] OSC_TOP = OSC_W'(RC_DIV - 1);

  // Elaboration check: pin bus is 8 bits wide, oscillator needs a real divider
  if (DATA_W != 8 || RC_DIV < 2) begin : g_bad_param
    $error("asc_converter: DATA_W must be 8 and RC_DIV at least 2");
  end

  // One successive-approximation step: keep the trial bit if it does not overshoot
  function automatic logic [DATA_W-1:0] sar_step(input logic [DATA_W-1:0] sar,
                                                 input logic [IDX_W-1:0]  idx,
                                                 input logic [DATA_W-1:0] code);
    logic [DATA_W-1:0] trial;
    trial = sar | (DATA_W'(1) << idx);
    return (trial <= code) ? trial : sar;
  endfunction

  // Synchroniser stages: bit 0 select, 1 start, 2 read, 3 clock pin
  logic [3:0]        pin_s1_reg;
  logic [3:0]        pin_s2_reg;
  logic [DATA_W-1:0] code_s1_reg;
  logic [DATA_W-1:0] code_s2_reg;
  logic              clk_prev_reg;
  logic              armed_reg;
  logic              armed_next;
  logic [OSC_W-1:0]  osc_cnt_reg;
  logic [OSC_W-1:0]  osc_cnt_next;
  asc_dev_state_t    state_reg;
  asc_dev_state_t    state_next;
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  idx_next;
  logic [DATA_W-1:0] sar_reg;
  logic [DATA_W-1:0] sar_next;
  logic [DATA_W-1:0] latch_reg;
  logic [DATA_W-1:0] latch_next;
  logic              done_n_reg;
  logic              done_n_next;
  logic              completed_reg;
  logic              aborted_reg;

  // Two-flop synchronisers; only the second stage is read by logic
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_reg  <= 4'hF;
      pin_s2_reg  <= 4'hF;
      code_s1_reg <= '0;
      code_s2_reg <= '0;
    end else begin
      pin_s1_reg  <= {bus.clock_input_pin, bus.read_strobe_n,
                      bus.start_strobe_n, bus.device_select_n};
      pin_s2_reg  <= pin_s1_reg;
      code_s1_reg <= analog_code_i;
      code_s2_reg <= code_s1_reg;
    end
  end

  // Synchronised pin levels
  wire cs_low   = ~pin_s2_reg[0];
  wire wr_low   = ~pin_s2_reg[1];
  wire rd_low   = ~pin_s2_reg[2];
  wire clk_lvl  = pin_s2_reg[3];

  // Start is taken when select and write were both low and one returns high
  wire both_low   = cs_low & wr_low;
  wire start_fire = armed_reg & ~both_low;
  assign armed_next = both_low ? 1'b1 : (start_fire ? 1'b0 : armed_reg);

  // Conversion step tick from the chosen clock source
  wire ext_tick = clk_lvl & ~clk_prev_reg;
  wire osc_tick = (osc_cnt_reg == OSC_TOP);
  wire conv_tick = (clk_src_i == ASC_CLK_EXT) ? ext_tick : osc_tick;
  assign osc_cnt_next = osc_tick ? '0 : osc_cnt_reg + OSC_W'(1);

  // Sequencer decode
  wire               converting = (state_reg == DEV_CONV);
  wire [DATA_W-1:0]  sar_new    = sar_step(sar_reg, idx_reg, code_s2_reg);
  wire               last_step  = converting & conv_tick & (idx_reg == '0);
  // A restart on the finishing cycle wins: the result is discarded
  wire               complete   = last_step & ~start_fire;
  wire               abort      = converting & start_fire;

  // Sequencer next state; any accepted start resets the sequencer
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    sar_next   = sar_reg;
    if (start_fire) begin
      state_next = DEV_CONV;
      idx_next   = IDX_TOP;
      sar_next   = '0;
    end else if (converting && conv_tick) begin
      sar_next = sar_new;
      if (idx_reg == '0) begin
        state_next = DEV_IDLE;
      end else begin
        idx_next = idx_reg - IDX_W'(1);
      end
    end
  end

  // Result latch only changes on a finished conversion
  assign latch_next = complete ? sar_new : latch_reg;

  // Done flag: completion sets it low and beats a same-cycle read clear
  wire done_clear = cs_low & (rd_low | wr_low);
  always_comb begin
    done_n_next = done_n_reg;
    if (complete) begin
      done_n_next = 1'b0;
    end else if (done_clear || start_fire) begin
      done_n_next = 1'b1;
    end
  end

  // Control and datapath registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_prev_reg  <= 1'b1;
      armed_reg     <= 1'b0;
      osc_cnt_reg   <= '0;
      state_reg     <= DEV_IDLE;
      idx_reg       <= '0;
      sar_reg       <= '0;
      latch_reg     <= `ASC_LATCH_RST;
      done_n_reg    <= 1'b1;
      completed_reg <= 1'b0;
      aborted_reg   <= 1'b0;
    end else begin
      clk_prev_reg  <= clk_lvl;
      armed_reg     <= armed_next;
      osc_cnt_reg   <= osc_cnt_next;
      state_reg     <= state_next;
      idx_reg       <= idx_next;
      sar_reg       <= sar_next;
      latch_reg     <= latch_next;
      done_n_reg    <= done_n_next;
      completed_reg <= complete;
      aborted_reg   <= abort;
    end
  end

  // Pin drive; enable is combinational from synchronised strobes
  assign bus.conversion_done_n = done_n_reg;
  assign bus.dev_data          = latch_reg;
  assign bus.dev_data_oe       = cs_low & rd_low;

  // Status outputs
  assign busy_o      = converting;
  assign result_o    = latch_reg;
  assign completed_o = completed_reg;
  assign aborted_o   = aborted_reg;

endmodule // asc_converter

`default_nettype wire

// ---- src/asc_host.sv ----
// Purpose: Host end: address decode, strobes, wait states, burst capture, free run.
// Assumes: Same system clock as the converter; done flag and data are synchronised.
// Notes:   Requests are ignored in free-running mode.
`default_nettype none
`include "asc_defines.svh"

module asc_host #(
  parameter int DATA_W      = `ASC_DATA_W,
  parameter int STROBE_CYC  = `ASC_STROBE_CYC,
  parameter int WAIT_STATES = `ASC_WAIT_STATES,
  parameter int INIT_CYC    = `ASC_INIT_CYC,
  parameter int CLK_HALF    = `ASC_CPU_CLK_HALF,
  parameter int BURST_LEN   = `ASC_BURST_LEN
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // Pins toward the converter
  asc_if.host                       bus,
  // User requests
  input  wire asc_pkg::asc_map_t    map_i,
  input  wire logic                 free_run_i,
  input  wire logic [15:0]          addr_i,
  input  wire logic                 single_req_i,
  input  wire logic                 burst_req_i,
  // Results
  output logic                      ready_o,
  output logic [DATA_W-1:0]         data_o,
  output logic                      data_valid_o,
  output logic                      burst_done_o,
  input  wire logic [$clog2(BURST_LEN)-1:0] rd_idx_i,
  output logic [DATA_W-1:0]         rd_data_o
);
  import asc_pkg::*;

  localparam int CNT_W = $clog2(STROBE_CYC + WAIT_STATES + INIT_CYC + CLK_HALF + 1);
  localparam int BI_W  = $clog2(BURST_LEN);
  localparam logic [CNT_W-1:0] STRB_TOP = CNT_W'(STROBE_CYC + WAIT_STATES - 1);
  localparam logic [CNT_W-1:0] INIT_TOP = CNT_W'(INIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_TOP = CNT_W'(CLK_HALF - 1);
  localparam logic [BI_W-1:0]  LAST_IDX = BI_W'(BURST_LEN - 1);

  // Elaboration check on counts the logic can serve
  if (DATA_W != 8 || STROBE_CYC < 4 || INIT_CYC < 4 || CLK_HALF < 2 || BURST_LEN < 2)
  begin : g_bad_param
    $error("asc_host: parameter out of range");
  end

  asc_host_state_t   state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  init_cnt_reg;
  logic              init_reg;
  logic [CNT_W-1:0]  div_cnt_reg;
  logic              cpu_clk_reg;
  logic              burst_reg;
  logic [BI_W-1:0]   bidx_reg;
  logic              done_s1_reg;
  logic              done_s2_reg;
  logic [DATA_W-1:0] data_s1_reg;
  logic [DATA_W-1:0] data_s2_reg;
  logic [DATA_W-1:0] data_reg;
  logic              valid_reg;
  logic              bdone_reg;
  logic [DATA_W-1:0] store_mem [BURST_LEN];

  // Address decode per mapping; io decodes the low port byte only
  wire io_hit  = (addr_i[7:0] == `ASC_PORT_ADDR);
  wire mem_hit = (addr_i == `ASC_MEM_ADDR);
  wire sel_hit = (map_i == ASC_MAP_IO) ? io_hit : mem_hit;

  // Strobe phases drive the strobe of the chosen address space
  wire wr_phase = (state_reg == H_WRITE);
  wire rd_phase = (state_reg == H_READ);
  wire io_write_strobe_n     = ~(wr_phase & (map_i == ASC_MAP_IO));
  wire io_read_strobe_n      = ~(rd_phase & (map_i == ASC_MAP_IO));
  wire memory_write_strobe_n = ~(wr_phase & (map_i == ASC_MAP_MEM));
  wire memory_read_strobe_n  = ~(rd_phase & (map_i == ASC_MAP_MEM));
  wire strb_end = (cnt_reg == STRB_TOP);

  // Free run ties start to the done flag, pulled low by the kick pulse
  assign bus.device_select_n = free_run_i ? 1'b0 : ~((wr_phase | rd_phase) & sel_hit);
  assign bus.start_strobe_n  = free_run_i ? (bus.conversion_done_n & ~init_reg)
                                          : (io_write_strobe_n & memory_write_strobe_n);
  assign bus.read_strobe_n   = free_run_i ? 1'b1 : (io_read_strobe_n & memory_read_strobe_n);
  assign bus.clock_input_pin = cpu_clk_reg;

  // Kick pulse, conversion clock divider and pin synchronisers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_cnt_reg <= '0;
      init_reg     <= 1'b1;
      div_cnt_reg  <= '0;
      cpu_clk_reg  <= 1'b0;
      done_s1_reg  <= 1'b1;
      done_s2_reg  <= 1'b1;
      data_s1_reg  <= '0;
      data_s2_reg  <= '0;
    end else begin
      if (init_reg) begin
        init_cnt_reg <= init_cnt_reg + CNT_W'(1);
        init_reg     <= (init_cnt_reg != INIT_TOP);
      end
      div_cnt_reg <= (div_cnt_reg == HALF_TOP) ? '0 : div_cnt_reg + CNT_W'(1);
      cpu_clk_reg <= (div_cnt_reg == HALF_TOP) ? ~cpu_clk_reg : cpu_clk_reg;
      done_s1_reg <= bus.conversion_done_n;
      done_s2_reg <= done_s1_reg;
      data_s1_reg <= bus.bus_data;
      data_s2_reg <= data_s1_reg;
    end
  end

  // Transfer sequencer: start, wait for done, read, then repeat for bursts
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= H_IDLE;
      cnt_reg   <= '0;
      burst_reg <= 1'b0;
      bidx_reg  <= '0;
      data_reg  <= '0;
      valid_reg <= 1'b0;
      bdone_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      bdone_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          cnt_reg <= '0;
          if (!free_run_i && sel_hit && (single_req_i || burst_req_i)) begin
            burst_reg <= burst_req_i;
            bidx_reg  <= '0;
            state_reg <= H_WRITE;
          end
        end
        H_WRITE: begin
          cnt_reg <= strb_end ? '0 : cnt_reg + CNT_W'(1);
          if (strb_end) begin
            state_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (!done_s2_reg) begin
            state_reg <= H_READ;
          end
        end
        H_READ: begin
          cnt_reg <= strb_end ? '0 : cnt_reg + CNT_W'(1);
          if (strb_end) begin
            data_reg  <= data_s2_reg;
            state_reg <= H_STORE;
          end
        end
        H_STORE: begin
          valid_reg <= 1'b1;
          if (burst_reg && bidx_reg != LAST_IDX) begin
            bidx_reg  <= bidx_reg + BI_W'(1);
            state_reg <= H_WRITE;
          end else begin
            bdone_reg <= burst_reg;
            state_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Burst storage in consecutive slots
  always_ff @(posedge sys_clk_i) begin
    if (state_reg == H_STORE && burst_reg) begin
      store_mem[bidx_reg] <= data_reg;
    end
  end

  assign ready_o      = (state_reg == H_IDLE) & ~free_run_i;
  assign data_o       = data_reg;
  assign data_valid_o = valid_reg;
  assign burst_done_o = bdone_reg;
  assign rd_data_o    = store_mem[rd_idx_i];

endmodule // asc_host

`default_nettype wire

// ---- tb/asc_monitor.sv ----
// Purpose: Concurrent checks on the pins between host and converter.
// Assumes: One clock; converter pins pass two sync flops before use.
// Notes:   Watches only the link where both parties are design code.
`default_nettype none

module asc_monitor (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  // Link pins
  input wire logic       device_select_n,
  input wire logic       start_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       conversion_done_n,
  input wire logic [7:0] dev_data,
  input wire logic       dev_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Bus drive follows the synchronised select and read, two edges late
  chk_oe_needs_sel: assert property (dev_data_oe |->
    $past(!device_select_n, 2) && $past(!read_strobe_n, 2)) else $error("data driven unselected");
  chk_oe_on_read: assert property ((!device_select_n && !read_strobe_n)[*3]
    |-> dev_data_oe) else $error("data not driven in read");
  chk_data_steady: assert property (dev_data_oe && $past(dev_data_oe) |->
    $stable(dev_data)) else $error("data moved during read");
  // Latch changes only with the completion edge of the done flag
  chk_latch_at_done: assert property ($changed(dev_data) |->
    $fell(conversion_done_n)) else $error("latch changed without completion");
  chk_done_holds: assert property ($fell(conversion_done_n) |->
    !conversion_done_n[*2]) else $error("done flag glitch");
  chk_done_cleared: assert property ((!device_select_n && !read_strobe_n)[*4]
    |=> conversion_done_n) else $error("done flag not cleared by read");
  // A restart just before the end must not let the flag fall
  chk_no_done_restart: assert property ($fell(conversion_done_n) |->
    $past(start_strobe_n || device_select_n, 4)) else $error("done after restart");
  chk_start_selected: assert property ($fell(start_strobe_n) |->
    !device_select_n) else $error("start without select");
  chk_read_width: assert property ($fell(read_strobe_n) |->
    !read_strobe_n[*8]) else $error("read strobe too short");
  chk_rd_wr_apart: assert property (!(!read_strobe_n && !start_strobe_n))
    else $error("read and start together");
endmodule // asc_monitor

`default_nettype wire

// ---- tb/adc_start_restart_bus_control_tb_top.sv ----
// Purpose: Self-checking bench for the host and converter pair.
// Assumes: Expected results equal the stand-in analog code held per conversion.
// Notes:   A second converter on its own link is driven by the bench for restarts.
`default_nettype none

module adc_start_restart_bus_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;

  // Stimulus and observed signals
  logic         sys_clk_i = 1'b0;
  logic         resetn_i  = 1'b0;
  asc_clk_src_t clk_src;
  asc_map_t     map_sel;
  logic         free_run, single_req, burst_req;
  logic [15:0]  addr;
  logic [3:0]   rd_idx;
  logic [7:0]   code, seed, exp_lat, result, result2, data, rd_data;
  logic         busy, completed, aborted, busy2, completed2, aborted2;
  logic         ready, data_valid, burst_done, hit, low;
  logic [7:0]   exp_q[$];
  int           error_cnt = 0;
  int           num_checks = 0;
  int           i, n, cnt;

  asc_if bus_if ();
  asc_if lab_if ();

  asc_converter i_asc_converter (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(bus_if.dev),
    .clk_src_i(clk_src), .analog_code_i(code), .busy_o(busy), .result_o(result),
    .completed_o(completed), .aborted_o(aborted));
  asc_converter i_asc_converter_2 (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .bus(lab_if.dev), .clk_src_i(ASC_CLK_RC), .analog_code_i(code), .busy_o(busy2),
    .result_o(result2), .completed_o(completed2), .aborted_o(aborted2));
  asc_host i_asc_host (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(bus_if.host),
    .map_i(map_sel), .free_run_i(free_run), .addr_i(addr), .single_req_i(single_req),
    .burst_req_i(burst_req), .ready_o(ready), .data_o(data), .data_valid_o(data_valid),
    .burst_done_o(burst_done), .rd_idx_i(rd_idx), .rd_data_o(rd_data));
  asc_monitor i_asc_monitor (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .device_select_n(bus_if.device_select_n), .start_strobe_n(bus_if.start_strobe_n),
    .read_strobe_n(bus_if.read_strobe_n), .conversion_done_n(bus_if.conversion_done_n),
    .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe));

  // Clock, 4 ns period
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One host conversion; returns once the read result is valid
  task automatic host_single(input asc_map_t m, input logic [15:0] a);
    for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge sys_clk_i);
    map_sel    = m;
    addr       = a;
    single_req = 1'b1;
    @(negedge sys_clk_i);
    single_req = 1'b0;
    for (n = 0; n < 2000 && data_valid !== 1'b1; n++) @(negedge sys_clk_i);
    chk_bit(data_valid, 1'b1);
    chk_bit(busy, 1'b0);
  endtask

  // Bench-driven strobe on the second link, held ten cycles
  task automatic lab_strobe(input logic rd);
    @(negedge sys_clk_i);
    lab_if.device_select_n = 1'b0;
    lab_if.read_strobe_n   = !rd;
    lab_if.start_strobe_n  = rd;
    repeat (10) @(negedge sys_clk_i);
    if (rd) chk_byte(lab_if.bus_data, exp_lat);
    lab_if.device_select_n = 1'b1;
    lab_if.read_strobe_n   = 1'b1;
    lab_if.start_strobe_n  = 1'b1;
    // Two edges clear the synchronisers; a restart pulse lands on the caller's next edge
    repeat (2) @(negedge sys_clk_i);
    if (rd) chk_byte(lab_if.bus_data, 8'hFF);
  endtask

  // Watchdog, well beyond the expected run length
  initial begin
    #160000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    clk_src = ASC_CLK_EXT;
    map_sel = ASC_MAP_IO;
    {free_run, single_req, burst_req} = 3'b000;
    addr    = 16'h0000;
    rd_idx  = 4'h0;
    seed    = 8'h50;
    code    = seed;
    exp_lat = 8'h00;
    lab_if.device_select_n = 1'b1;
    lab_if.read_strobe_n   = 1'b1;
    lab_if.start_strobe_n  = 1'b1;
    lab_if.clock_input_pin = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    chk_bit(bus_if.conversion_done_n, 1'b1);
    chk_byte(result, 8'h00);
    chk_bit(ready, 1'b1);
    // Every clock source under every mapping
    for (i = 0; i < 4; i++) begin
      clk_src = asc_clk_src_t'(i[0]);
      seed    = lfsr(seed);
      code    = seed;
      host_single(asc_map_t'(i[1]), i[1] ? 16'h4000 : 16'h4040);
      chk_byte(data, code);
      chk_byte(result, code);
    end
    // Address miss is ignored
    addr       = 16'h1234;
    single_req = 1'b1;
    hit        = 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge sys_clk_i);
      single_req = 1'b0;
      hit        = hit | !bus_if.device_select_n;
    end
    chk_bit(hit, 1'b0);
    // Burst of sixteen with a new code per conversion
    addr      = 16'h4000;
    burst_req = 1'b1;
    @(negedge sys_clk_i);
    burst_req = 1'b0;
    for (n = 0; n < 8000 && exp_q.size() < 16; n++) begin
      @(negedge sys_clk_i);
      if (data_valid === 1'b1) begin
        exp_q.push_back(code);
        chk_bit(burst_done, exp_q.size() == 16);
        seed = lfsr(seed);
        code = seed;
      end
    end
    chk_bit(exp_q.size() == 16, 1'b1);
    for (i = 0; i < 16; i++) begin
      @(negedge sys_clk_i);
      rd_idx = i[3:0];
      #1;
      chk_byte(rd_data, exp_q[i]);
    end
    // Second link: complete, read, then restart a running conversion
    exp_lat = code;
    lab_strobe(1'b0);
    for (n = 0; n < 600 && completed2 !== 1'b1; n++) @(negedge sys_clk_i);
    chk_byte(result2, exp_lat);
    lab_strobe(1'b1);
    chk_bit(lab_if.conversion_done_n, 1'b1);
    seed = lfsr(seed);
    code = seed;
    lab_strobe(1'b0);
    repeat (50) @(negedge sys_clk_i);
    chk_bit(busy2, 1'b1);
    seed = lfsr(seed);
    code = seed;
    lab_strobe(1'b0);
    {hit, low} = 2'b00;
    for (n = 0; n < 600 && completed2 !== 1'b1; n++) begin
      @(negedge sys_clk_i);
      if (aborted2 === 1'b1) begin
        hit = 1'b1;
        chk_byte(result2, exp_lat);
      end
      low = low | (!lab_if.conversion_done_n && !completed2);
    end
    chk_bit(hit, 1'b1);
    chk_bit(low, 1'b0);
    chk_byte(result2, code);
    // Free running after a second reset with its kick pulse
    resetn_i = 1'b0;
    free_run = 1'b1;
    clk_src  = ASC_CLK_EXT;
    repeat (12) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    chk_bit(ready, 1'b0);
    cnt = 0;
    {hit, low} = 2'b00;
    // Free run restarts only after done falls, so no conversion is ever cut short
    for (n = 0; n < 1500; n++) begin
      @(negedge sys_clk_i);
      if (completed === 1'b1) cnt++;
      hit = hit | aborted;
      low = low | busy;
    end
    chk_bit(cnt >= 3, 1'b1);
    chk_bit(hit, 1'b0);
    chk_bit(low, 1'b1);
    chk_byte(result, code);
    wrap_up;
  end
endmodule // adc_start_restart_bus_control_tb_top

`default_nettype wire
